// *** logic/scdp_duty.sv ***
// Purpose: duty correction of the sampled oscillator
// Assumes: osc_sync already passed a two-stage synchroniser
// Notes: fast oscillators are rebuilt at half-period duty
`timescale 1ns/100ps
module scdp_duty (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// sampled oscillator
	input wire logic osc_sync,
	// corrected clock, oscillator rise strobe and duty enable
	output logic corr_clk,
	output logic corr_rise,
	output logic duty_on
);
	logic prev_ff;
	logic corr_ff;
	logic [7:0] cnt_ff;
	logic [7:0] period_ff;
	logic [7:0] cnt_inc;
	logic nxt_corr;

	assign corr_rise = osc_sync & ~prev_ff;
	assign cnt_inc = (cnt_ff == 8'hFF) ? cnt_ff : 8'(cnt_ff + 8'h01);
	assign duty_on = (period_ff != 8'h00) &&
		(period_ff <= scdp_pkg::DUTY_MAX_PERIOD);
	// slow clocks pass as sampled; rebuilding them would add no margin
	assign nxt_corr = !duty_on ? osc_sync :
		corr_rise ? 1'b1 :
		(cnt_inc >= {1'b0, period_ff[7:1]}) ? 1'b0 : corr_ff;
	assign corr_clk = corr_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_ff <= 1'b0;
			corr_ff <= 1'b0;
			cnt_ff <= 8'h00;
			period_ff <= 8'h00;
		end else begin
			prev_ff <= osc_sync;
			corr_ff <= nxt_corr;
			cnt_ff <= corr_rise ? 8'h00 : cnt_inc;
			if (corr_rise)
				period_ff <= cnt_inc;
		end
	end

	AST_DUTY_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
		duty_on && corr_rise |=> corr_clk)
		else $error("corrected clock did not rise on oscillator edge");
endmodule : scdp_duty

// *** logic/scdp_pkg.sv ***
// Purpose: shared constants for the system clock divider and prescaler
// Assumes: pclk at 100 MHz, APB with 32-bit data
// Notes: printed divide register offset is a word index, byte = index * 4
package scdp_pkg;
	localparam int unsigned PCLK_HZ = 100_000_000;
	// duty stage engages at or above this oscillator rate
	localparam int unsigned DUTY_MIN_HZ = 5_000_000;
	// longest oscillator period, in pclk cycles, that still counts as fast
	localparam logic [7:0] DUTY_MAX_PERIOD = 8'(PCLK_HZ / DUTY_MIN_HZ);
	localparam int unsigned SETTLE_US = 500;
	localparam int unsigned SETTLE_CYC = SETTLE_US * (PCLK_HZ / 1_000_000);
	localparam int unsigned RESET_PULSE_CYC = 10;
	// default standby exit wait, counted in system clock ticks
	localparam int unsigned WAKE_TICKS = 8192;
	localparam int unsigned PRESC_W = 12;
	localparam int unsigned SETTLE_W = 17;
	localparam int unsigned WAKE_W = 16;
	// register indices; byte address is index * 4
	localparam logic [21:0] IDX_DIVIDE = 22'h0EE01B;
	localparam logic [21:0] IDX_CTRL = 22'h0EE01C;
	localparam logic [21:0] IDX_STATUS = 22'h0EE01D;
	localparam logic [7:0] DIVIDE_RESET = 8'hFC;
	localparam logic [7:0] DIVIDE_FIXED_ONES = 8'hFC;
	localparam logic [7:0] CTRL_RESET = 8'h01;
	localparam int unsigned CTRL_CLKOUT_BIT = 0;
	localparam int unsigned STAT_SETTLED_BIT = 0;
	localparam int unsigned STAT_PEND_BIT = 1;
	localparam int unsigned STAT_WAKE_BIT = 2;
	localparam int unsigned STAT_DUTY_BIT = 3;
	localparam int unsigned STAT_RATIO_LSB = 4;
	typedef enum logic [1:0] {
		SCDP_RATIO_SELECT_HIGH = 2'b00,
		SCDP_DIV2 = 2'b01,
		SCDP_DIV4 = 2'b10,
		SCDP_DIV8 = 2'b11
	} scdp_ratio_t;
	typedef enum logic [1:0] {
		SCDP_RUN = 2'b00,
		SCDP_STBY = 2'b01,
		SCDP_WAKE = 2'b10
	} scdp_state_t;
endpackage : scdp_pkg

// *** logic/scdp_presc.sv ***
// Purpose: prescaler chain of system clock enables
// Assumes: tick is one pclk wide per system clock rising edge
// Notes: en[k] pulses once per 2**(k+1) ticks
`timescale 1ns/100ps
module scdp_presc #(
	parameter int unsigned W = 12
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// system clock tick
	input wire logic tick,
	// divided enables
	output logic [W-1:0] en
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] en_ff;
	logic [W-1:0] nxt_en;

	genvar k;
	generate
		for (k = 0; k < W; k++) begin : g_stage
			assign nxt_en[k] = tick && (&cnt_ff[k:0]);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= '0;
			en_ff <= '0;
		end else begin
			en_ff <= nxt_en;
			if (tick)
				cnt_ff <= W'(cnt_ff + 1'b1);
		end
	end
	assign en = en_ff;
endmodule : scdp_presc

// *** logic/scdp_top.sv ***
// Purpose: system clock divider with prescaler and APB registers
// Assumes: oscillator and standby pin are asynchronous to pclk
// Notes: system clock is rebuilt from pclk samples of the oscillator
//
// How it works
// - at or above 5 MHz the oscillator passes a duty correction stage
// - prescaler makes enables at system clock / 2 up to / 4096
// - system clock comes from the divider, never the raw oscillator
// - new divide ratio takes effect while running, no reset needed
// - divided system clock can be driven on the clock output pin
// - chip reset and hardware standby load divide register with FC
// - software standby keeps the divide register and its ratio
// - upper six divide bits ignore writes and read as ones
// - select 00, 01, 10, 11 gives 1/1, 1/2, 1/4, 1/8
// - clock output stays quiet until 500 us after clock start
// - peripheral timing enables scale with the system clock
// - standby exit wait counts divided system clock ticks
// - output frequency equals input frequency times selected ratio
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
module scdp_top #(
	parameter int unsigned SETTLE_CYCLES = scdp_pkg::SETTLE_CYC,
	parameter int unsigned WAKE_CYCLES = scdp_pkg::WAKE_TICKS
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [23:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins
	input wire logic oscillator_input_pin,
	input wire logic hw_standby_pin,
	output logic sysclk_pin,
	// power control
	input wire logic sw_standby_req,
	output logic wake_done,
	// internal clock enables
	output logic sys_tick,
	output logic [scdp_pkg::PRESC_W-1:0] presc_en
);
	// synchroniser: index 0 oscillator, index 1 hardware standby
	logic [1:0] meta_ff;
	logic [1:0] sync_ff;
	logic osc_sync;
	logic hw_stby;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= 2'b00;
			sync_ff <= 2'b00;
		end else begin
			meta_ff <= {hw_standby_pin, oscillator_input_pin};
			sync_ff <= meta_ff;
		end
	end
	assign osc_sync = sync_ff[0];
	assign hw_stby = sync_ff[1];

	// duty correction
	logic corr_clk;
	logic corr_rise;
	logic duty_on;

	scdp_duty u_duty (
		.pclk(pclk),
		.presetn(presetn),
		.osc_sync(osc_sync),
		.corr_clk(corr_clk),
		.corr_rise(corr_rise),
		.duty_on(duty_on)
	);

	// apb decode
	logic acc;
	logic setup;
	logic hit_div;
	logic hit_ctrl;
	logic hit_stat;
	logic hit;
	logic wr_div;
	logic wr_ctrl;

	assign setup = psel && !penable;
	assign acc = psel && penable;
	assign hit_div = (paddr[23:2] == scdp_pkg::IDX_DIVIDE);
	assign hit_ctrl = (paddr[23:2] == scdp_pkg::IDX_CTRL);
	assign hit_stat = (paddr[23:2] == scdp_pkg::IDX_STATUS);
	assign hit = (paddr[1:0] == 2'b00) && (hit_div || hit_ctrl || hit_stat);
	assign wr_div = acc && pwrite && hit && hit_div;
	assign wr_ctrl = acc && pwrite && hit && hit_ctrl;
	assign pready = 1'b1;
	assign pslverr = acc && !hit;

	// registers
	logic [1:0] div_ff;
	logic [7:0] ctrl_ff;
	logic [7:0] div_read;
	logic [7:0] stat_read;

	// only the select field is stored; the rest is wired to ones
	assign div_read = scdp_pkg::DIVIDE_FIXED_ONES | {6'h00, div_ff};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div_ff <= scdp_pkg::DIVIDE_RESET[1:0];
		else if (hw_stby)
			div_ff <= scdp_pkg::DIVIDE_RESET[1:0];
		else if (wr_div)
			div_ff <= pwdata[1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_ff <= scdp_pkg::CTRL_RESET;
		else if (wr_ctrl)
			ctrl_ff <= pwdata[7:0];
	end

	// divider
	logic [2:0] div_cnt_ff;
	logic [2:0] cnt_inc;
	logic [1:0] ratio_ff;
	logic [2:0] tick_mask;
	logic at_boundary;
	logic phi_level;
	logic sys_tick_ff;
	logic nxt_tick;

	assign cnt_inc = 3'(div_cnt_ff + 3'h1);
	// every divided clock rises when the count wraps
	assign at_boundary = corr_rise && (div_cnt_ff == 3'h7);
	assign tick_mask = (ratio_ff == scdp_pkg::SCDP_DIV2) ? 3'h1 :
		(ratio_ff == scdp_pkg::SCDP_DIV4) ? 3'h3 :
		(ratio_ff == scdp_pkg::SCDP_DIV8) ? 3'h7 : 3'h0;
	assign nxt_tick = corr_rise && ((cnt_inc & tick_mask) == 3'h0);
	assign phi_level = (ratio_ff == scdp_pkg::SCDP_DIV2) ? ~div_cnt_ff[0] :
		(ratio_ff == scdp_pkg::SCDP_DIV4) ? ~div_cnt_ff[1] :
		(ratio_ff == scdp_pkg::SCDP_DIV8) ? ~div_cnt_ff[2] :
		corr_clk;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_ff <= 3'h0;
			ratio_ff <= scdp_pkg::DIVIDE_RESET[1:0];
			sys_tick_ff <= 1'b0;
		end else begin
			sys_tick_ff <= nxt_tick;
			if (corr_rise)
				div_cnt_ff <= cnt_inc;
			// a ratio change waits for the common edge, so no short phase
			if (at_boundary)
				ratio_ff <= div_ff;
		end
	end
	assign sys_tick = sys_tick_ff;

	// prescaler
	scdp_presc #(
		.W(scdp_pkg::PRESC_W)
	) u_presc (
		.pclk(pclk),
		.presetn(presetn),
		.tick(sys_tick_ff),
		.en(presc_en)
	);

	// settle delay from clock start
	logic started_ff;
	logic settled_ff;
	logic [scdp_pkg::SETTLE_W-1:0] settle_cnt_ff;
	logic settle_hit;

	// reset itself cannot cover the wait, so a counter runs once the first oscillator rise is seen
	assign settle_hit = (settle_cnt_ff ==
		scdp_pkg::SETTLE_W'(SETTLE_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			started_ff <= 1'b0;
			settled_ff <= 1'b0;
			settle_cnt_ff <= '0;
		end else begin
			if (corr_rise)
				started_ff <= 1'b1;
			if (started_ff && !settled_ff) begin
				settle_cnt_ff <= scdp_pkg::SETTLE_W'(settle_cnt_ff + 1'b1);
				if (settle_hit)
					settled_ff <= 1'b1;
			end
		end
	end

	// clock output pin
	logic sysclk_ff;
	logic nxt_sysclk;

	assign nxt_sysclk = settled_ff && ctrl_ff[scdp_pkg::CTRL_CLKOUT_BIT] &&
		phi_level;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sysclk_ff <= 1'b0;
		else
			sysclk_ff <= nxt_sysclk;
	end
	assign sysclk_pin = sysclk_ff;

	// software standby and exit wait
	scdp_pkg::scdp_state_t state_ff;
	scdp_pkg::scdp_state_t nxt_state;
	logic [scdp_pkg::WAKE_W-1:0] wake_cnt_ff;
	logic wake_hit;
	logic wake_done_ff;

	assign wake_hit = sys_tick_ff && (wake_cnt_ff ==
		scdp_pkg::WAKE_W'(WAKE_CYCLES - 1));

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			scdp_pkg::SCDP_RUN: begin
				if (sw_standby_req)
					nxt_state = scdp_pkg::SCDP_STBY;
			end
			scdp_pkg::SCDP_STBY: begin
				if (!sw_standby_req)
					nxt_state = scdp_pkg::SCDP_WAKE;
			end
			scdp_pkg::SCDP_WAKE: begin
				if (wake_hit)
					nxt_state = scdp_pkg::SCDP_RUN;
			end
			default: nxt_state = scdp_pkg::SCDP_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= scdp_pkg::SCDP_RUN;
			wake_cnt_ff <= '0;
			wake_done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			wake_done_ff <= (state_ff == scdp_pkg::SCDP_WAKE) && wake_hit;
			if (state_ff != scdp_pkg::SCDP_WAKE)
				wake_cnt_ff <= '0;
			else if (sys_tick_ff)
				wake_cnt_ff <= scdp_pkg::WAKE_W'(wake_cnt_ff + 1'b1);
		end
	end
	assign wake_done = wake_done_ff;

	// read data, captured in the setup phase
	logic [31:0] prdata_ff;
	logic [31:0] rd_mux;

	assign stat_read = {2'b00, ratio_ff, duty_on,
		state_ff == scdp_pkg::SCDP_WAKE, ratio_ff != div_ff, settled_ff};
	assign rd_mux = !hit ? 32'h0000_0000 :
		hit_div ? {24'h00_0000, div_read} :
		hit_ctrl ? {24'h00_0000, ctrl_ff} :
		{24'h00_0000, stat_read};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_ff <= 32'h0000_0000;
		else if (setup)
			prdata_ff <= rd_mux;
	end
	assign prdata = prdata_ff;

	// checks
	AST_HW_STBY_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		hw_stby |=> div_read == scdp_pkg::DIVIDE_RESET)
		else $error("divide register not reloaded in hardware standby");
	AST_RSVD_ONES: assert property (@(posedge pclk) disable iff (!presetn)
		acc && hit && hit_div && !pwrite |-> prdata[7:2] == 6'h3F)
		else $error("reserved divide bits not read as ones");
	AST_WRITE_TAKES: assert property (@(posedge pclk) disable iff (!presetn)
		wr_div && !hw_stby |=> div_ff == $past(pwdata[1:0]))
		else $error("divide write not stored");
	AST_SWITCH_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
		ratio_ff != $past(ratio_ff) |-> $past(at_boundary))
		else $error("ratio switched away from common edge");
	AST_APPLY_BOUND: assert property (@(posedge pclk) disable iff (!presetn)
		corr_rise && div_cnt_ff == 3'h7 |=> ratio_ff == $past(div_ff))
		else $error("pending ratio not applied at boundary");
	AST_DIV8_TICK: assert property (@(posedge pclk) disable iff (!presetn)
		sys_tick_ff && ratio_ff == scdp_pkg::SCDP_DIV8 |->
		div_cnt_ff == 3'h0)
		else $error("divide by eight tick off phase");
	AST_QUIET_OUT: assert property (@(posedge pclk) disable iff (!presetn)
		!$past(settled_ff) |-> !sysclk_pin)
		else $error("clock driven out before settling");
	AST_OUT_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
		settled_ff && ctrl_ff[scdp_pkg::CTRL_CLKOUT_BIT] ##1
		$stable(ratio_ff) |-> sysclk_pin == $past(phi_level))
		else $error("clock pin does not follow divided clock");
	AST_PRESC_HALF: assert property (@(posedge pclk) disable iff (!presetn)
		presc_en[0] |-> $past(sys_tick_ff))
		else $error("prescaler enable without system tick");
	AST_STBY_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == scdp_pkg::SCDP_STBY && !hw_stby && !wr_div |=>
		$stable(div_ff))
		else $error("divide register changed in software standby");
	AST_WAKE_END: assert property (@(posedge pclk) disable iff (!presetn)
		wake_done |-> $past(state_ff) == scdp_pkg::SCDP_WAKE &&
		$past(sys_tick_ff))
		else $error("standby wait ended off a system tick");
	COV_SWITCH: cover property (@(posedge pclk) disable iff (!presetn)
		at_boundary && div_ff != ratio_ff);
	COV_SETTLED: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(settled_ff));
	COV_WAKE: cover property (@(posedge pclk) disable iff (!presetn)
		wake_done);
	COV_DUTY: cover property (@(posedge pclk) disable iff (!presetn)
		duty_on && corr_rise);
endmodule : scdp_top

// *** tb/scdp_osc_model.sv ***
// Purpose: oscillator source and reset driver beside the divider
// Assumes: half period in ns comes from the bench
// Notes: oscillator runs free, as a crystal would
`timescale 1ns/100ps
module scdp_osc_model (
	// clock and control
	input wire logic pclk,
	input wire logic rst_req,
	input wire logic [15:0] half_ns,
	// pins toward the device
	output logic osc,
	output logic presetn
);
	logic [3:0] hold_ff;
	initial osc = 1'b0;
	initial hold_ff = 4'hC;
	// unknown period at time zero must not spin at zero delay
	always begin
		if (half_ns > 16'h0)
			#(half_ns);
		else
			#1;
		osc = ~osc;
	end
	// settle span is shortened by parameter and counted after reset, so 12 cycles need not cover it
	always @(posedge pclk) begin
		if (rst_req)
			hold_ff <= 4'hC;
		else if (hold_ff != 4'h0)
			hold_ff <= hold_ff - 4'h1;
	end
	assign presetn = (hold_ff == 4'h0);
endmodule : scdp_osc_model

// *** tb/scdp_top_bench.sv ***
// Purpose: self-checking bench of the system clock divider
// Assumes: oscillator period 8 pclk unless a scenario changes it
// Notes: settle and wake counts shortened by parameters
`timescale 1ns/100ps
module scdp_top_bench;
	localparam int SET = 20;
	localparam int WK = 4;
	localparam logic [23:0] A_DIV = {scdp_pkg::IDX_DIVIDE, 2'b00};
	localparam logic [23:0] A_CTL = {scdp_pkg::IDX_CTRL, 2'b00};
	localparam logic [23:0] A_ST = {scdp_pkg::IDX_STATUS, 2'b00};
	logic pclk, presetn, psel, penable, pwrite, osc, hw_stby, sw_req;
	logic rst_req, pready, pslverr, sysclk_pin, wake_done, sys_tick, e;
	logic [23:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] half_ns;
	logic [scdp_pkg::PRESC_W-1:0] presc_en;
	logic [scdp_pkg::PRESC_W+1:0] w;
	int error_cnt, cmp_count, g;
	assign w = {presc_en, sysclk_pin, sys_tick};
	scdp_osc_model scdp_osc_model_i (.pclk(pclk), .rst_req(rst_req),
		.half_ns(half_ns), .osc(osc), .presetn(presetn));
	scdp_top #(.SETTLE_CYCLES(SET), .WAKE_CYCLES(WK)) scdp_top_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .oscillator_input_pin(osc),
		.hw_standby_pin(hw_stby), .sysclk_pin(sysclk_pin),
		.sw_standby_req(sw_req), .wake_done(wake_done),
		.sys_tick(sys_tick), .presc_en(presc_en));
	task chk32(input string s, input logic [31:0] x, input logic [31:0] y);
		cmp_count++;
		if (y !== x) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", s, x, y);
		end
	endtask : chk32
	task complete_run;
		if (error_cnt == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	task automatic apb(input logic wr, input logic [23:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// only the watchdog ends a wait for the answer
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// period in pclk between two rises of w[b]; bounded wait
	task automatic gap(input int b);
		int c = 0;
		int n = 0;
		logic p = 1'b1;
		g = 0;
		while (n < 2 && c < 5000) begin
			@(negedge pclk);
			c++;
			if (n == 1)
				g++;
			if (w[b] === 1'b1 && p === 1'b0)
				n++;
			p = w[b];
		end
	endtask : gap
	task automatic t_settle;
		logic hi = 1'b0;
		wait (presetn === 1'b1);
		repeat (SET) begin
			@(negedge pclk);
			hi = hi | sysclk_pin;
		end
		chk32("pin quiet", 32'h0, {31'h0, hi});
		gap(1);
		chk32("pin period", 32'h8, 32'(g));
	endtask : t_settle
	task t_regs;
		apb(1'b0, A_DIV, 32'h0);
		chk32("divide reset", 32'hFC, q);
		apb(1'b0, A_CTL, 32'h0);
		chk32("ctrl reset", 32'h1, q);
		apb(1'b1, A_DIV, 32'h3);
		apb(1'b0, A_DIV, 32'h0);
		chk32("divide 03", 32'hFF, q);
		apb(1'b1, A_DIV, 32'hFFFFFF01);
		apb(1'b0, A_DIV, 32'h0);
		chk32("divide 01", 32'hFD, q);
		apb(1'b1, A_DIV + 24'h1, 32'h0);
		chk32("misaligned err", 32'h1, {31'h0, e});
		apb(1'b0, A_ST + 24'h4, 32'h0);
		chk32("unmapped err", 32'h1, {31'h0, e});
		chk32("unmapped data", 32'h0, q);
		apb(1'b0, A_DIV, 32'h0);
		chk32("divide kept", 32'hFD, q);
		apb(1'b1, A_CTL, 32'h0);
		// pin register lags the control write by one cycle
		repeat (2) @(posedge pclk);
		e = 1'b0;
		repeat (20) begin
			@(negedge pclk);
			e = e | sysclk_pin;
		end
		chk32("pin off", 32'h0, {31'h0, e});
		apb(1'b1, A_CTL, 32'h1);
	endtask : t_regs
	task t_ratio;
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, A_DIV, 32'(s));
			// switch lands within eight oscillator rises
			repeat (72) @(posedge pclk);
			gap(0);
			gap(0);
			chk32("tick period", 32'(8 << s), 32'(g));
			gap(1);
			chk32("pin period", 32'(8 << s), 32'(g));
			for (int k = 0; k < 4; k++) begin
				gap(2 + k);
				chk32("presc period", 32'(8 << (s + k + 1)), 32'(g));
			end
		end
	endtask : t_ratio
	task t_duty;
		apb(1'b1, A_DIV, 32'h0);
		// 20 pclk is exactly 5 MHz, 22 pclk just below
		for (int i = 0; i < 2; i++) begin
			half_ns <= 16'(100 + 10 * i);
			repeat (300) @(posedge pclk);
			gap(0);
			chk32("slow tick", 32'(20 + 2 * i), 32'(g));
			apb(1'b0, A_ST, 32'h0);
			chk32("duty on", 32'(i == 0), {31'h0, q[scdp_pkg::STAT_DUTY_BIT]});
		end
		half_ns <= 16'h0028;
		repeat (300) @(posedge pclk);
	endtask : t_duty
	task t_hw;
		apb(1'b1, A_DIV, 32'h2);
		hw_stby <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b1, A_DIV, 32'h3);
		apb(1'b0, A_DIV, 32'h0);
		chk32("hw standby", 32'hFC, q);
		hw_stby <= 1'b0;
		apb(1'b0, A_DIV, 32'h0);
		chk32("after hw", 32'hFC, q);
	endtask : t_hw
	task automatic t_sw;
		int c = 0;
		int n = 0;
		apb(1'b1, A_DIV, 32'h2);
		gap(0);
		gap(0);
		@(posedge pclk);
		sw_req <= 1'b1;
		repeat (20) @(posedge pclk);
		sw_req <= 1'b0;
		// a tick in the release cycle still falls in standby
		@(posedge pclk);
		while (wake_done !== 1'b1 && c < 3000) begin
			@(negedge pclk);
			c++;
			if (sys_tick === 1'b1)
				n++;
		end
		chk32("wake ticks", 32'(WK), 32'(n));
		apb(1'b0, A_DIV, 32'h0);
		chk32("sw standby", 32'hFE, q);
		gap(0);
		gap(0);
		chk32("ratio kept", 32'h20, 32'(g));
	endtask : t_sw
	task t_mid;
		apb(1'b1, A_DIV, 32'h3);
		rst_req <= 1'b1;
		@(posedge pclk);
		rst_req <= 1'b0;
		// reset falls only after this edge's updates settle
		wait (presetn === 1'b0);
		wait (presetn === 1'b1);
		apb(1'b0, A_DIV, 32'h0);
		chk32("second reset", 32'hFC, q);
	endtask : t_mid
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		{psel, penable, pwrite, hw_stby, sw_req, rst_req} = 6'h0;
		paddr = 24'h0;
		pwdata = 32'h0;
		half_ns = 16'h0028;
		error_cnt = 0;
		cmp_count = 0;
		t_settle;
		t_regs;
		t_ratio;
		t_duty;
		t_hw;
		t_sw;
		t_mid;
		complete_run;
	end
	initial begin
		repeat (90000) @(posedge pclk);
		error_cnt++;
		complete_run;
	end
endmodule : scdp_top_bench
